// ===== verilog/sscc_pkg.sv
// constants, field layout and state types of the synchronous serial channel control
//
// What this block does
// - mode field 00 gives 8-bit transfers, 01 gives 16-bit transfers, 10 gives a free-running clock.
// - the control register resets to zero, i.e. 8-bit, no tail, hold tail, prescaler, slowest ratio.
// - any control register write during a transfer halts that transfer.
// - tail enable 0 ends after the data bits, 1 appends a tail mark after the data.
// - with the tail enabled, latch select 0 sends a hold tail and 1 sends a latch tail.
// - clock source 0 drives the clock pin from the prescaler, 1 takes an external clock on it.
// - prescale codes 000 to 110 divide mclk by 1024,256,64,32,16,8,4; code 111 is subclock/4.
// - every completed transfer raises a completion request.
// - the channel uses a two-way clock pin, a data-in pin and a data-out pin.
// - the output pins can be switched to open-drain drive.
// - writing 1 to the start flag starts a transfer; the flag reads 1 until the transfer ends.
// - data leaves least significant bit first while input bits enter from the top.
// - an external clock falling edge after a completed transfer sets overrun; read-1 then write-0 clears it.
// - a read-only flag shows the tail mark being sent, low when idle or shifting data.
package sscc_pkg;

   // ----------------------------------------------------------------
   // register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [15:0] SSCC_OFS_CTRL = 16'hffa0;
   localparam logic [15:0] SSCC_OFS_STAT = 16'hffa1;
   localparam logic [15:0] SSCC_OFS_UPPER = 16'hffa2;
   localparam logic [15:0] SSCC_OFS_LOWER = 16'hffa3;
   localparam logic [15:0] SSCC_OFS_RXQ_LO = 16'hffa4;
   localparam logic [15:0] SSCC_OFS_RXQ_HI = 16'hffa5;
   localparam logic [15:0] SSCC_OFS_AUX = 16'hffa6;
   localparam logic [15:0] SSCC_OFS_STOP = 16'hfffa;

   // ----------------------------------------------------------------
   // reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] SSCC_CTRL_RST = 8'h00;
   localparam logic [7:0] SSCC_STAT_RST = 8'h9c;
   localparam logic [7:0] SSCC_STOP_RST = 8'hff;
   localparam logic [7:0] SSCC_AUX_RST = 8'h00;
   localparam logic [7:0] SSCC_STAT_FIXED = 8'h9c;
   localparam int SSCC_MODE_HI = 7;
   localparam int SSCC_MODE_LO = 6;
   localparam int SSCC_TAIL_EN = 5;
   localparam int SSCC_LATCH = 4;
   localparam int SSCC_SRC = 3;
   localparam int SSCC_ST_LEVEL = 6;
   localparam int SSCC_ST_OVR = 5;
   localparam int SSCC_ST_TAIL = 1;
   localparam int SSCC_ST_START = 0;
   localparam int SSCC_STOP_BIT = 7;
   localparam int SSCC_AUX_OD = 0;
   localparam int SSCC_AUX_FULL = 6;
   localparam int SSCC_AUX_EMPTY = 7;

   // ----------------------------------------------------------------
   // counts
   // ----------------------------------------------------------------
   localparam logic [4:0] SSCC_LAST8 = 5'h07;
   localparam logic [4:0] SSCC_LAST16 = 5'h0f;
   localparam logic [2:0] SSCC_TAIL_LAST = 3'h3;
   localparam int SSCC_FIFO_WIDTH = 16;
   localparam int SSCC_FIFO_DEPTH = 16;
   // half-period masks for mclk/1024 .. mclk/4
   localparam logic [9:0] SSCC_HALF_MASK [0:6] = '{10'h1ff, 10'h07f, 10'h01f, 10'h00f,
      10'h007, 10'h003, 10'h001};
   localparam logic [2:0] SSCC_SEL_SUB = 3'h7;

   typedef enum logic [1:0] {
      SSCC_M8 = 2'b00,
      SSCC_M16 = 2'b01,
      SSCC_MCONT = 2'b10,
      SSCC_MRSV = 2'b11
   } sscc_mode_e;

   typedef enum logic [2:0] {
      SSCC_IDLE = 3'b000,
      SSCC_SHIFT = 3'b001,
      SSCC_TAIL = 3'b011,
      SSCC_PARK = 3'b010,
      SSCC_CONT = 3'b110
   } sscc_state_e;

endpackage

// ===== verilog/sscc_sync2.sv
// two-flop synchroniser for one pin level
`timescale 1ns/1ps
module sscc_sync2 (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic pinIn,
   output logic pinSync
);
   logic stage1;

   // only the second flop is read outside
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         stage1 <= 1'b1;
         pinSync <= 1'b1;
      end else begin
         stage1 <= pinIn;
         pinSync <= stage1;
      end
   end
endmodule

// ===== verilog/sscc_fifo.sv
// received-word queue with valid/ready on both sides
`timescale 1ns/1ps
module sscc_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic inValid,
   input wire logic [WIDTH-1:0] inData,
   output logic inReady,
   output logic outValid,
   output logic [WIDTH-1:0] outData,
   input wire logic outReady
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [0:DEPTH-1];
   logic [AW:0] wrPtr;
   logic [AW:0] rdPtr;
   wire push = inValid && inReady;
   wire pop = outValid && outReady;

   // extra pointer bit tells full from empty
   assign inReady = (wrPtr[AW] == rdPtr[AW]) || (wrPtr[AW-1:0] != rdPtr[AW-1:0]);
   assign outValid = wrPtr != rdPtr;
   assign outData = mem[rdPtr[AW-1:0]];

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wrPtr[AW-1:0]] <= inData;
      end
   end

   // pointers
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         wrPtr <= '0;
         rdPtr <= '0;
      end else begin
         if (push) begin
            wrPtr <= wrPtr + 1'b1;
         end
         if (pop) begin
            rdPtr <= rdPtr + 1'b1;
         end
      end
   end
endmodule

// ===== verilog/sscc_ctrl.sv
// synchronous serial channel: registers, clock source, shifter, tail mark and pins
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module sscc_ctrl
   import sscc_pkg::*;
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [15:0] regAddr,
   input wire logic [7:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [7:0] regRdData,
   input wire logic sckIn,
   output logic sckOut,
   output logic sckOe,
   input wire logic siIn,
   output logic soOut,
   output logic soOe,
   input wire logic subClk,
   output logic xferDone
);

   // ----------------------------------------------------------------
   // register decode
   // ----------------------------------------------------------------
   logic [7:0] ctrl;
   logic [7:0] clkStop;
   logic [7:0] aux;
   logic [15:0] shreg;
   logic ovr;
   logic ovrSeen;
   logic soLvl;
   logic doneOnce;
   sscc_state_e state;

   wire ctrlWr = regWr && (regAddr == SSCC_OFS_CTRL);
   wire statWr = regWr && (regAddr == SSCC_OFS_STAT);
   wire upWr = regWr && (regAddr == SSCC_OFS_UPPER);
   wire loWr = regWr && (regAddr == SSCC_OFS_LOWER);
   wire auxWr = regWr && (regAddr == SSCC_OFS_AUX);
   wire stopWr = regWr && (regAddr == SSCC_OFS_STOP);
   wire statRd = regRd && (regAddr == SSCC_OFS_STAT);
   wire rxqPop = regRd && (regAddr == SSCC_OFS_RXQ_LO);

   // field views
   wire sscc_mode_e mode = sscc_mode_e'(ctrl[SSCC_MODE_HI:SSCC_MODE_LO]);
   wire tailEn = ctrl[SSCC_TAIL_EN];
   wire latchSel = ctrl[SSCC_LATCH];
   wire extClk = ctrl[SSCC_SRC];
   wire [2:0] preSel = ctrl[2:0];
   wire standby = !clkStop[SSCC_STOP_BIT];
   wire openDrain = aux[SSCC_AUX_OD];
   wire running = state != SSCC_IDLE;
   wire startReq = statWr && regWrData[SSCC_ST_START] && !running && !standby;
   wire tailFlag = state == SSCC_TAIL;
   wire [4:0] lastBit = (mode == SSCC_M16) ? SSCC_LAST16 : SSCC_LAST8;

   // ----------------------------------------------------------------
   // clock sources
   // ----------------------------------------------------------------
   logic [9:0] preCnt;
   logic subPrev;
   logic subHalf;
   logic extPrev;
   logic sckLvl;
   logic [4:0] bitCnt;
   logic [2:0] halfCnt;
   wire subSync;
   wire extSync;
   wire siSync;

   sscc_sync2 u_subSync (.mclk(mclk), .rst_b(rst_b), .pinIn(subClk), .pinSync(subSync));
   sscc_sync2 u_extSync (.mclk(mclk), .rst_b(rst_b), .pinIn(sckIn), .pinSync(extSync));
   sscc_sync2 u_siSync (.mclk(mclk), .rst_b(rst_b), .pinIn(siIn), .pinSync(siSync));

   // half-period ticks: prescaler mask, or every second subclock rise
   wire subRise = subSync && !subPrev;
   wire [9:0] halfMask = SSCC_HALF_MASK[(preSel == SSCC_SEL_SUB) ? 3'h0 : preSel];
   wire preTick = (preCnt & halfMask) == halfMask;
   wire subTick = subRise && subHalf;
   wire intTick = (preSel == SSCC_SEL_SUB) ? subTick : preTick;
   // edges of the clock that times the shifter
   wire extFall = extPrev && !extSync;
   wire extRise = !extPrev && extSync;
   wire riseEv = extClk ? extRise : (intTick && !sckLvl);
   wire fallEv = extClk ? extFall : (intTick && sckLvl);
   wire halfEv = riseEv || fallEv;

   // free-running dividers; the prescaler never stops so ratio changes take effect quickly
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         preCnt <= '0;
         subPrev <= 1'b1;
         subHalf <= 1'b0;
         extPrev <= 1'b1;
      end else begin
         preCnt <= preCnt + 10'h001;
         subPrev <= subSync;
         subHalf <= subRise ? !subHalf : subHalf;
         extPrev <= extSync;
      end
   end

   // ----------------------------------------------------------------
   // transfer engine
   // ----------------------------------------------------------------
   wire fifoInRdy;
   wire fifoOutVal;
   wire [15:0] fifoOutData;
   wire finish = (state == SSCC_PARK) && fifoInRdy; // queue full keeps the channel busy
   wire lastRise = (state == SSCC_SHIFT) && riseEv && (bitCnt == lastBit);
   wire haltReq = (ctrlWr && running) || standby;

   sscc_state_e next_state;
   always_comb begin
      next_state = state;
      case (state)
         SSCC_IDLE: begin
            if (startReq) begin
               next_state = (mode == SSCC_MCONT) ? SSCC_CONT : SSCC_SHIFT;
            end
         end
         SSCC_SHIFT: begin
            if (lastRise) begin
               next_state = tailEn ? SSCC_TAIL : SSCC_PARK;
            end
         end
         SSCC_TAIL: begin
            if (halfEv && (halfCnt == SSCC_TAIL_LAST)) begin
               next_state = SSCC_PARK;
            end
         end
         SSCC_PARK: begin
            if (fifoInRdy) begin
               next_state = SSCC_IDLE;
            end
         end
         SSCC_CONT: next_state = SSCC_CONT;
         default: next_state = SSCC_IDLE;
      endcase
      if (haltReq) begin
         next_state = SSCC_IDLE;
      end
   end

   // state, counters and internal clock level
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         state <= SSCC_IDLE;
         bitCnt <= '0;
         halfCnt <= '0;
         sckLvl <= 1'b1;
      end else begin
         state <= next_state;
         bitCnt <= (state != SSCC_SHIFT) ? 5'h00 : (riseEv ? bitCnt + 5'h01 : bitCnt);
         halfCnt <= (state != SSCC_TAIL) ? 3'h0 : (halfEv ? halfCnt + 3'h1 : halfCnt);
         if (next_state == SSCC_IDLE || next_state == SSCC_PARK) begin
            sckLvl <= 1'b1;
         end else if (intTick && running) begin
            sckLvl <= !sckLvl;
         end
      end
   end

   // shift register: lsb leaves first, input enters from the top
   always_ff @(posedge mclk) begin
      if (state == SSCC_SHIFT && riseEv) begin
         if (mode == SSCC_M16) begin
            shreg <= {siSync, shreg[15:1]};
         end else begin
            shreg[7:0] <= {siSync, shreg[7:1]};
         end
      end else begin
         if (upWr) begin
            shreg[15:8] <= regWrData;
         end
         if (loWr) begin
            shreg[7:0] <= regWrData;
         end
      end
   end

   // data-out level: last bit is held after a transfer without tail, tail level during and after the mark
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         soLvl <= 1'b0;
      end else if (startReq && mode != SSCC_MCONT) begin
         soLvl <= shreg[0];
      end else if (state == SSCC_SHIFT && riseEv && !lastRise) begin
         soLvl <= shreg[1];
      end else if (lastRise && tailEn) begin
         soLvl <= !latchSel;
      end else if (statWr && !running) begin
         soLvl <= regWrData[SSCC_ST_LEVEL];
      end
   end

   // overrun: set wins over the clear, clear needs a prior read of 1
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ovr <= 1'b0;
         ovrSeen <= 1'b0;
         doneOnce <= 1'b0;
      end else begin
         doneOnce <= finish ? 1'b1 : (startReq ? 1'b0 : doneOnce);
         if (extClk && !running && doneOnce && fallEv) begin
            ovr <= 1'b1;
         end else if (statWr && !regWrData[SSCC_ST_OVR] && ovrSeen) begin
            ovr <= 1'b0;
         end
         ovrSeen <= (statRd && ovr) ? 1'b1 : (ovr ? ovrSeen : 1'b0);
      end
   end

   // ----------------------------------------------------------------
   // software registers and read path
   // ----------------------------------------------------------------
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         ctrl <= SSCC_CTRL_RST;
         clkStop <= SSCC_STOP_RST;
         aux <= SSCC_AUX_RST;
      end else begin
         ctrl <= ctrlWr ? regWrData : ctrl;
         clkStop <= stopWr ? regWrData : clkStop;
         aux <= auxWr ? {7'h00, regWrData[SSCC_AUX_OD]} : aux;
      end
   end

   wire [7:0] statView = SSCC_STAT_FIXED | {1'b0, soLvl, ovr, 3'b000, tailFlag, running};
   wire [7:0] auxView = {!fifoOutVal, !fifoInRdy, 5'h00, openDrain};
   logic [7:0] next_rdData;
   always_comb begin
      next_rdData = 8'h00;
      case (regAddr)
         SSCC_OFS_CTRL: next_rdData = ctrl;
         SSCC_OFS_STAT: next_rdData = statView;
         SSCC_OFS_UPPER: next_rdData = shreg[15:8];
         SSCC_OFS_LOWER: next_rdData = shreg[7:0];
         SSCC_OFS_RXQ_LO: next_rdData = fifoOutData[7:0];
         SSCC_OFS_RXQ_HI: next_rdData = fifoOutData[15:8];
         SSCC_OFS_AUX: next_rdData = auxView;
         SSCC_OFS_STOP: next_rdData = clkStop;
         default: next_rdData = 8'h00;
      endcase
   end

   // received words queue up so software can fall behind by a few transfers
   sscc_fifo #(.WIDTH(SSCC_FIFO_WIDTH), .DEPTH(SSCC_FIFO_DEPTH)) u_rxq (
      .mclk(mclk),
      .rst_b(rst_b),
      .inValid(state == SSCC_PARK),
      .inData(shreg),
      .inReady(fifoInRdy),
      .outValid(fifoOutVal),
      .outData(fifoOutData),
      .outReady(rxqPop)
   );

   // ----------------------------------------------------------------
   // registered outputs and pins
   // ----------------------------------------------------------------
   wire intDrive = !extClk && !standby;
   always_ff @(posedge mclk) begin
      if (!rst_b) begin
         regRdData <= 8'h00;
         xferDone <= 1'b0;
         sckOut <= 1'b1;
         sckOe <= 1'b1;
         soOut <= 1'b0;
         soOe <= 1'b1;
      end else begin
         regRdData <= regRd ? next_rdData : 8'h00;
         xferDone <= finish;
         // open-drain only pulls low, the line idles high on its pull-up
         sckOut <= openDrain ? 1'b0 : sckLvl;
         sckOe <= intDrive && (!openDrain || !sckLvl);
         soOut <= openDrain ? 1'b0 : soLvl;
         soOe <= !openDrain || !soLvl;
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   chk_ctrl_reset_zero: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(rst_b) |-> ctrl == SSCC_CTRL_RST) else $error("control not zero after reset");
   chk_ctrl_write_halt: assert property (@(posedge mclk) disable iff (!rst_b)
      ctrlWr && running |=> state == SSCC_IDLE) else $error("control write did not halt");
   chk_start_busy: assert property (@(posedge mclk) disable iff (!rst_b)
      startReq |=> running && statView[SSCC_ST_START]) else $error("start did not set busy");
   chk_done_pulse: assert property (@(posedge mclk) disable iff (!rst_b)
      finish && !haltReq |=> xferDone && !running) else $error("completion not reported");
   chk_bit_count: assert property (@(posedge mclk) disable iff (!rst_b)
      lastRise && !haltReq && !tailEn |=> state == SSCC_PARK && $past(bitCnt) == lastBit)
      else $error("transfer ended on wrong bit");
   chk_tail_cause: assert property (@(posedge mclk) disable iff (!rst_b)
      $rose(tailFlag) |-> $past(tailEn) && $past(state) == SSCC_SHIFT)
      else $error("tail mark without tail enable");
   chk_ext_no_drive: assert property (@(posedge mclk) disable iff (!rst_b)
      extClk ##1 extClk |-> !sckOe) else $error("clock pin driven with external source");
   chk_ovr_set: assert property (@(posedge mclk) disable iff (!rst_b)
      extClk && !running && doneOnce && fallEv |=> ovr) else $error("overrun not flagged");
   chk_lsb_shift: assert property (@(posedge mclk) disable iff (!rst_b)
      state == SSCC_SHIFT && riseEv && !upWr && !loWr |=> shreg[6:0] == $past(shreg[7:1]))
      else $error("shift direction wrong");
endmodule

// ===== verif/sscc_peer.sv
// far-side serial device model: shifts a word in and out, can drive the clock pin
`timescale 1ns/1ps
module sscc_peer (
   input wire logic mclk,
   input wire logic pinSck,
   input wire logic soPin,
   input wire logic load,
   input wire logic [15:0] txWord,
   input wire logic [4:0] nBits,
   input wire logic extGo,
   input wire logic [4:0] extPulses,
   output logic extSck,
   output logic siIn,
   output logic [15:0] rxWord,
   output logic [15:0] falls
);
   logic pinPrev;
   logic [4:0] idx;
   logic extOwn;

   // --------------------------------------------
   // data line
   // --------------------------------------------
   // released line shows the inverse of the last bit so a stale level is never read
   assign siIn = (idx < nBits) ? txWord[idx[3:0]] : ~txWord[nBits[3:0] - 4'h1];

   initial begin
      extSck = 1'b1;
      extOwn = 1'b0;
      pinPrev = 1'b1;
      idx = 5'h00;
      rxWord = 16'h0000;
      falls = 16'h0000;
   end

   // falls tracked in the mclk domain: the design's data is sampled mid-bit
   always @(posedge mclk) begin
      pinPrev <= pinSck;
      if (pinPrev && !pinSck) begin
         rxWord <= {soPin, rxWord[15:1]};
         falls <= falls + 16'h0001;
      end
   end

   // next bit right at the pin rise: the 2-flop input path leaves no slack at mclk/4;
   // as clock master the model holds each bit a few mclk past its own rise instead
   always @(posedge pinSck or posedge load) begin
      if (load) begin
         idx <= 5'h00;
      end else if (idx < nBits) begin
         idx <= #(extOwn ? 110 : 0) idx + 5'h01;
      end
   end

   // external clock: idles high, 16 mclk per period, only for the pulses asked for
   always @(posedge mclk) begin
      if (extGo) begin
         extOwn = 1'b1;
         repeat (extPulses) begin
            repeat (8) @(posedge mclk);
            extSck <= 1'b0;
            repeat (8) @(posedge mclk);
            extSck <= 1'b1;
         end
         // keep the late bit change for the last rise too
         @(posedge mclk);
         extOwn = 1'b0;
      end
   end
endmodule

// ===== verif/tb_sync_serial_channel_ctrl.sv
// self-checking bench for the synchronous serial channel control
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) begin nCompared++; if ((got) !== (exp)) begin miscompares++; \
   $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); end end
module tb_sync_serial_channel_ctrl;
   import sscc_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] regAddr = 16'h0000;
   logic [7:0] regWrData = 8'h00;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic subClk = 1'b0;
   logic peerLoad = 1'b0;
   logic extGo = 1'b0;
   logic [15:0] peerTx = 16'h0000;
   logic [4:0] peerBits = 5'h08;
   logic [4:0] extPulses = 5'h08;
   logic [7:0] regRdData;
   logic [7:0] rd;
   logic [15:0] rxWord;
   logic [15:0] falls;
   logic [15:0] f0;
   logic sckOut, sckOe, soOut, soOe, xferDone, siIn, extSck, pinSck, soPin;
   int miscompares = 0;
   int nCompared = 0;
   int gap;
   int seen;
   int ratio [8] = '{1024, 256, 64, 32, 16, 8, 4, 40};

   // --------------------------------------------
   // clocks, pins and instances
   // --------------------------------------------
   initial forever #12.5 mclk = ~mclk;
   // subclock period is 10 mclk, so subclock/4 gives a 40 mclk serial period
   initial begin
      #7;
      forever #125 subClk = ~subClk;
   end
   assign pinSck = sckOe ? sckOut : extSck;
   assign soPin = soOe ? soOut : 1'b1;

   sscc_ctrl uut (.mclk(mclk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
      .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .sckIn(pinSck), .sckOut(sckOut),
      .sckOe(sckOe), .siIn(siIn), .soOut(soOut), .soOe(soOe), .subClk(subClk),
      .xferDone(xferDone));
   sscc_peer peer (.mclk(mclk), .pinSck(pinSck), .soPin(soPin), .load(peerLoad),
      .txWord(peerTx), .nBits(peerBits), .extGo(extGo), .extPulses(extPulses),
      .extSck(extSck), .siIn(siIn), .rxWord(rxWord), .falls(falls));

   // --------------------------------------------
   // bus and wait tasks
   // --------------------------------------------
   task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regWrData <= d;
      regWr <= 1'b1;
      @(posedge mclk);
      regWr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
      @(posedge mclk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge mclk);
      regRd <= 1'b0;
      #1;
      d = regRdData;
   endtask
   task automatic report_and_stop();
      $display("comparisons %0d, mismatches %0d", nCompared, miscompares);
      if (miscompares == 0 && nCompared > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wait_done(input int bound);
      int n;
      n = 0;
      do begin
         tick(1);
         n++;
         if (n > bound) begin
            miscompares++;
            $display("completion wait ran out at %0t", $time);
            report_and_stop();
         end
      end while (xferDone !== 1'b1);
   endtask
   // cycles until the next falling edge of the clock pin
   task automatic fall_gap(output int n);
      logic [15:0] fs;
      fs = falls;
      n = 0;
      while (falls === fs) begin
         tick(1);
         n++;
         if (n > 5000) begin
            miscompares++;
            $display("clock edge wait ran out at %0t", $time);
            report_and_stop();
         end
      end
   endtask
   task automatic start_xfer(input logic [7:0] ctrl, input logic [15:0] d,
      input logic [15:0] tx);
      reg_write(SSCC_OFS_CTRL, ctrl);
      reg_write(SSCC_OFS_UPPER, d[15:8]);
      reg_write(SSCC_OFS_LOWER, d[7:0]);
      peerTx <= tx;
      peerBits <= ctrl[6] ? 5'h10 : 5'h08;
      peerLoad <= 1'b1;
      @(posedge mclk);
      peerLoad <= 1'b0;
      reg_write(SSCC_OFS_STAT, 8'h01);
   endtask
   task automatic pop_lower(output logic [7:0] d);
      reg_read(SSCC_OFS_RXQ_HI, d);
      reg_read(SSCC_OFS_RXQ_LO, d);
   endtask

   // --------------------------------------------
   // tests
   // --------------------------------------------
   initial begin
      repeat (5) @(posedge mclk);
      rst_b <= 1'b1;
      reg_read(SSCC_OFS_CTRL, rd);
      `CHECK_EQ(rd, 8'h00)
      reg_read(SSCC_OFS_STAT, rd);
      `CHECK_EQ(rd, 8'h9c)
      reg_read(SSCC_OFS_STOP, rd);
      `CHECK_EQ(rd, 8'hff)
      reg_write(16'hffa8, 8'h55);
      reg_read(16'hffa8, rd);
      `CHECK_EQ(rd, 8'h00)
      reg_write(SSCC_OFS_CTRL, 8'h35);
      reg_read(SSCC_OFS_CTRL, rd);
      `CHECK_EQ(rd, 8'h35)
      $display("test reset and access done");
      // every prescaler code, one 8-bit transfer each
      for (int c = 0; c < 8; c++) begin
         start_xfer({5'h00, 3'(c)}, {8'h00, 8'h5a ^ 8'(c)}, {8'h00, 8'hc3 + 8'(c)});
         fall_gap(gap);
         fall_gap(gap);
         `CHECK_EQ(gap, ratio[c])
         reg_read(SSCC_OFS_STAT, rd);
         `CHECK_EQ(rd[0], 1'b1)
         wait_done(9000);
         `CHECK_EQ(rxWord[15:8], 8'h5a ^ 8'(c))
         `CHECK_EQ(sckOe, 1'b1)
         reg_read(SSCC_OFS_STAT, rd);
         `CHECK_EQ(rd[0], 1'b0)
         pop_lower(rd);
         `CHECK_EQ(rd, 8'hc3 + 8'(c))
      end
      $display("test prescaler codes done");
      // 16-bit: lower byte first, sixteen clocks
      f0 = falls;
      start_xfer(8'h46, 16'h1234, 16'habcd);
      wait_done(400);
      `CHECK_EQ(falls - f0, 16'h0010)
      `CHECK_EQ(rxWord, 16'h1234)
      reg_read(SSCC_OFS_RXQ_HI, rd);
      `CHECK_EQ(rd, 8'hab)
      reg_read(SSCC_OFS_RXQ_LO, rd);
      `CHECK_EQ(rd, 8'hcd)
      $display("test 16-bit done");
      // tail mark: hold then latch, data chosen so the tail level differs from the last bit
      for (int l = 0; l < 2; l++) begin
         seen = 0;
         start_xfer({3'b001, 1'(l), 4'h6}, {8'h00, l ? 8'hff : 8'h00}, 16'h0000);
         for (int k = 0; k < 60 && seen == 0; k++) begin
            reg_read(SSCC_OFS_STAT, rd);
            if (rd[1] === 1'b1) begin
               seen = 1;
               `CHECK_EQ(soOut, ~1'(l))
            end
         end
         `CHECK_EQ(seen, 1)
         wait_done(200);
         reg_read(SSCC_OFS_STAT, rd);
         `CHECK_EQ(rd[1], 1'b0)
         pop_lower(rd);
      end
      $display("test tail mark done");
      // control write in mid-transfer halts it
      start_xfer(8'h00, 16'h005a, 16'h0000);
      tick(100);
      reg_write(SSCC_OFS_CTRL, 8'h00);
      reg_read(SSCC_OFS_STAT, rd);
      `CHECK_EQ(rd[0], 1'b0)
      seen = 0;
      for (int k = 0; k < 3000; k++) begin
         tick(1);
         seen += int'(xferDone === 1'b1);
      end
      `CHECK_EQ(seen, 0)
      $display("test halt done");
      // external clock, then one extra clock pulse for overrun
      start_xfer(8'h08, 16'h0096, 16'h0069);
      `CHECK_EQ(sckOe, 1'b0)
      extPulses <= 5'h08;
      extGo <= 1'b1;
      @(posedge mclk);
      extGo <= 1'b0;
      wait_done(400);
      `CHECK_EQ(rxWord[15:8], 8'h96)
      pop_lower(rd);
      `CHECK_EQ(rd, 8'h69)
      extPulses <= 5'h01;
      extGo <= 1'b1;
      @(posedge mclk);
      extGo <= 1'b0;
      tick(30);
      reg_read(SSCC_OFS_STAT, rd);
      `CHECK_EQ(rd[5], 1'b1)
      reg_write(SSCC_OFS_STAT, 8'h00);
      reg_read(SSCC_OFS_STAT, rd);
      `CHECK_EQ(rd[5], 1'b0)
      $display("test external clock done");
      // continuous clock runs until a control write; data pins left as ports
      start_xfer(8'h86, 16'h0000, 16'h0000);
      f0 = falls;
      tick(100);
      `CHECK_EQ(falls - f0 > 16'h0014, 1'b1)
      reg_write(SSCC_OFS_CTRL, 8'h06);
      tick(20);
      f0 = falls;
      tick(40);
      `CHECK_EQ(falls, f0)
      $display("test continuous clock done");
      // queue: fill sixteen, seventeenth waits busy until a pop
      for (int i = 0; i < 17; i++) begin
         start_xfer(8'h06, 16'h0000, {8'h00, 8'h10 + 8'(i)});
         if (i < 16) wait_done(200);
      end
      reg_read(SSCC_OFS_AUX, rd);
      `CHECK_EQ(rd[SSCC_AUX_FULL], 1'b1)
      tick(200);
      reg_read(SSCC_OFS_STAT, rd);
      `CHECK_EQ(rd[0], 1'b1)
      pop_lower(rd);
      `CHECK_EQ(rd, 8'h10)
      wait_done(200);
      for (int i = 1; i < 17; i++) begin
         pop_lower(rd);
         `CHECK_EQ(rd, 8'h10 + 8'(i))
      end
      reg_read(SSCC_OFS_AUX, rd);
      `CHECK_EQ(rd[SSCC_AUX_EMPTY], 1'b1)
      $display("test queue done");
      // open-drain: a high level releases the data line
      reg_write(SSCC_OFS_AUX, 8'h01);
      reg_write(SSCC_OFS_STAT, 8'h40);
      tick(3);
      `CHECK_EQ(soOe, 1'b0)
      reg_write(SSCC_OFS_STAT, 8'h00);
      tick(3);
      `CHECK_EQ({soOe, soOut}, 2'b10)
      $display("test open drain done");
      report_and_stop();
   end
endmodule
